/* File: inc/dtx_cfg.svh */
`ifndef DTX_CFG_SVH
`define DTX_CFG_SVH

// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define DTX_SEL_DATA 1'b0
`define DTX_SEL_CTRL 1'b1
`define DTX_CTRL_RST 4'h0
`define DTX_RX_RST 4'h0
`define DTX_MID 8'h80

// ----------------------------------------
// Clock rates and burst timing
// ----------------------------------------
`define DTX_REF_HZ 64'd100000000
`define DTX_XTAL_HZ 64'd3579545
`define DTX_NCO_W 24
`define DTX_BURST_MS 64'd51
`define DTX_BURST_CYC ((`DTX_BURST_MS * `DTX_REF_HZ) / 64'd1000)

// ----------------------------------------
// Segment lengths in crystal periods
// ----------------------------------------
`define DTX_SEGS 32
`define DTX_SEG_L1 8'd160
`define DTX_SEG_L2 8'd146
`define DTX_SEG_L3 8'd132
`define DTX_SEG_L4 8'd118
`define DTX_SEG_H1 8'd92
`define DTX_SEG_H2 8'd84
`define DTX_SEG_H3 8'd76
`define DTX_SEG_H4 8'd68

`endif

/* File: inc/dtx_pkg.sv */
package dtx_pkg;

	// ----------------------------------------
	// Host bus pins as sampled each clock
	// ----------------------------------------
	typedef struct packed {
		logic cs_n;
		logic data_strobe;
		logic rw_wr;
		logic reg_pick_line;
		logic [3:0] data;
	} dtx_bus_in_t;

	// ----------------------------------------
	// Register layouts, b3 first
	// ----------------------------------------
	typedef struct packed {
		logic control_bank_toggle;
		logic irq_en;
		logic call_progress_select;
		logic tone_output_on;
	} dtx_ctrl_a_t;

	typedef struct packed {
		logic column_tone;
		logic single_tone;
		logic test_mode;
		logic burst_off;
	} dtx_ctrl_b_t;

	typedef struct packed {
		logic steer_n;
		logic rx_ready;
		logic tx_empty;
		logic irq_pend;
	} dtx_status_t;

	// One-hot row and column picks (2-of-8 code)
	typedef struct packed {
		logic [3:0] row;
		logic [3:0] col;
	} dtx_tone_sel_t;

	typedef enum logic [1:0] {
		DTX_IDLE = 2'b00,
		DTX_TONE = 2'b01,
		DTX_PAUSE = 2'b11
	} dtx_burst_t;

endpackage

/* File: src/dtx_sine_rom.sv */
`timescale 1ns/1ps
`include "dtx_cfg.svh"

module dtx_sine_rom #(
	parameter int unsigned AW = 5
) (
	// Clock
	input wire logic ref_clk,
	// Lookup
	input wire logic [AW-1:0] addr,
	output logic [7:0] sample_r
);

	// ----------------------------------------
	// One sine period, offset binary
	// ----------------------------------------
	function automatic logic [7:0] sine_at(input logic [4:0] a);
		logic [7:0] v;
		v = `DTX_MID;
		unique case (a)
			5'h00: v = 8'h80;
			5'h01: v = 8'h99;
			5'h02: v = 8'hb1;
			5'h03: v = 8'hc7;
			5'h04: v = 8'hda;
			5'h05: v = 8'hea;
			5'h06: v = 8'hf5;
			5'h07: v = 8'hfd;
			5'h08: v = 8'hff;
			5'h09: v = 8'hfd;
			5'h0a: v = 8'hf5;
			5'h0b: v = 8'hea;
			5'h0c: v = 8'hda;
			5'h0d: v = 8'hc7;
			5'h0e: v = 8'hb1;
			5'h0f: v = 8'h99;
			5'h10: v = 8'h80;
			5'h11: v = 8'h67;
			5'h12: v = 8'h4f;
			5'h13: v = 8'h39;
			5'h14: v = 8'h26;
			5'h15: v = 8'h16;
			5'h16: v = 8'h0b;
			5'h17: v = 8'h03;
			5'h18: v = 8'h01;
			5'h19: v = 8'h03;
			5'h1a: v = 8'h0b;
			5'h1b: v = 8'h16;
			5'h1c: v = 8'h26;
			5'h1d: v = 8'h39;
			5'h1e: v = 8'h4f;
			5'h1f: v = 8'h67;
		endcase
		return v;
	endfunction

	// Registered read keeps the sample glitch free
	always_ff @(posedge ref_clk) begin
		sample_r <= sine_at(addr[4:0]);
	end

endmodule

/* File: src/dtx_host_port.sv */
// Functional notes
// - Tone period is 32 equal segments
// - Transmit write latches code into 2-of-8
// - Segment divider resets, steps sine address
// - Transmit code matches receive code format
// - Sixteen pairs via two identical paths
// - Timing from free-running crystal rate
// - Burst then equal pause, 51 ms
// - After pause, flag transmitter ready
// - Call-progress mode doubles to 102 ms
// - Call-progress plus burst: transmit only
// - Single-tone mode, row or column
// - Strobe low at select fall: strobe+direction
// - Read high at select fall: read/write
// - Latch address per detected bus style
// - Status updates without strobe activity
// - Select line plus direction picks register
// - Receive read-only, transmit write-only
// - Bank bit sends next write to B
// - Open-drain alert or call-progress copy
// - Tone-on bit gates all transmission
// - Control B bit0 low enables burst
// - Status read clears interrupt and valid
// - Single tone: b3 column, else row
`timescale 1ns/1ps
`include "dtx_cfg.svh"

module dtx_host_port #(
	parameter logic [23:0] BURST_CYC = 24'(`DTX_BURST_CYC)
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Host bus
	input wire dtx_pkg::dtx_bus_in_t bus_i,
	output logic [3:0] data_out,
	output logic data_oe_n,
	// Open-drain alert pin
	output logic host_alert_or_tone_out,
	output logic host_alert_or_tone_out_oe_n,
	// Receiver side
	input wire logic rx_digit_valid,
	input wire logic [3:0] rx_digit,
	input wire logic rx_steer_n,
	input wire logic rx_cp_square,
	output logic rx_enable,
	// Tone outputs
	output logic [7:0] row_sample,
	output logic [7:0] col_sample,
	output logic tone_active
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Digit code to one row and one column
	function automatic dtx_pkg::dtx_tone_sel_t code_to_tone(input logic [3:0] c);
		dtx_pkg::dtx_tone_sel_t t;
		t = '{row: 4'h8, col: 4'h8};
		unique case (c)
			4'h1: t = '{row: 4'h1, col: 4'h1};
			4'h2: t = '{row: 4'h1, col: 4'h2};
			4'h3: t = '{row: 4'h1, col: 4'h4};
			4'h4: t = '{row: 4'h2, col: 4'h1};
			4'h5: t = '{row: 4'h2, col: 4'h2};
			4'h6: t = '{row: 4'h2, col: 4'h4};
			4'h7: t = '{row: 4'h4, col: 4'h1};
			4'h8: t = '{row: 4'h4, col: 4'h2};
			4'h9: t = '{row: 4'h4, col: 4'h4};
			4'ha: t = '{row: 4'h8, col: 4'h2};
			4'hb: t = '{row: 4'h8, col: 4'h1};
			4'hc: t = '{row: 4'h8, col: 4'h4};
			4'hd: t = '{row: 4'h1, col: 4'h8};
			4'he: t = '{row: 4'h2, col: 4'h8};
			4'hf: t = '{row: 4'h4, col: 4'h8};
			4'h0: t = '{row: 4'h8, col: 4'h8};
		endcase
		return t;
	endfunction

	// Segment length for a one-hot pick in either group
	function automatic logic [7:0] seg_len(input logic [3:0] oh, input logic high);
		logic [7:0] n;
		n = high ? `DTX_SEG_H4 : `DTX_SEG_L4;
		if (oh[0]) begin
			n = high ? `DTX_SEG_H1 : `DTX_SEG_L1;
		end else if (oh[1]) begin
			n = high ? `DTX_SEG_H2 : `DTX_SEG_L2;
		end else if (oh[2]) begin
			n = high ? `DTX_SEG_H3 : `DTX_SEG_L3;
		end
		return n;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam logic [`DTX_NCO_W-1:0] NCO_INC =
		`DTX_NCO_W'((`DTX_XTAL_HZ << `DTX_NCO_W) / `DTX_REF_HZ);

	logic [`DTX_NCO_W-1:0] nco_r;
	logic xtal_tick_r;
	logic cs_n_q_r, style_rw_r, sel_r;
	logic rd_q_r, wr_q_r;
	logic [3:0] wdata_r, rx_data_r;
	logic bank_b_r, code_loaded_r;
	dtx_pkg::dtx_ctrl_a_t ctrl_a_r;
	dtx_pkg::dtx_ctrl_b_t ctrl_b_r;
	dtx_pkg::dtx_tone_sel_t tone_sel_r;
	dtx_pkg::dtx_status_t status_r;
	dtx_pkg::dtx_burst_t st_r, st_nxt;
	logic [23:0] cnt_r, cnt_nxt;

	wire [`DTX_NCO_W:0] nco_sum = {1'b0, nco_r} + {1'b0, NCO_INC};

	// ----------------------------------------
	// Crystal-rate tick
	// ----------------------------------------

	// Free-running, so a burst never waits for the oscillator
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			nco_r <= '0;
			xtal_tick_r <= 1'b0;
		end else begin
			nco_r <= nco_sum[`DTX_NCO_W-1:0];
			xtal_tick_r <= nco_sum[`DTX_NCO_W];
		end
	end

	// ----------------------------------------
	// Bus style detection and strobe decode
	// ----------------------------------------
	wire cs_fall = cs_n_q_r & ~bus_i.cs_n;
	// Select-fall cycle is ignored: the style register still holds the previous access's style
	wire rd_act = ~bus_i.cs_n & ~cs_fall & (style_rw_r ? ~bus_i.data_strobe : (bus_i.data_strobe & bus_i.rw_wr));
	wire wr_act = ~bus_i.cs_n & ~cs_fall & (style_rw_r ? ~bus_i.rw_wr : (bus_i.data_strobe & ~bus_i.rw_wr));
	wire rd_end = rd_q_r & ~rd_act;
	wire wr_end = wr_q_r & ~wr_act;
	wire wr_tx = wr_end & (sel_r == `DTX_SEL_DATA);
	wire wr_ctl = wr_end & (sel_r == `DTX_SEL_CTRL);
	wire rd_stat_end = rd_end & (sel_r == `DTX_SEL_CTRL);

	// Style chosen afresh at every select fall; a tied-low select never re-detects
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cs_n_q_r <= 1'b1;
			style_rw_r <= 1'b0;
		end else begin
			cs_n_q_r <= bus_i.cs_n;
			if (cs_fall) begin
				style_rw_r <= bus_i.data_strobe;
			end
		end
	end

	// Multiplexed bus: address only valid at select fall; else follow until strobe
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sel_r <= `DTX_SEL_DATA;
		end else if (style_rw_r ? cs_fall : ~(rd_act | wr_act)) begin
			sel_r <= bus_i.reg_pick_line;
		end
	end

	// Write data sampled through the strobe, committed at its end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_q_r <= 1'b0;
			wr_q_r <= 1'b0;
			wdata_r <= '0;
		end else begin
			rd_q_r <= rd_act;
			wr_q_r <= wr_act;
			if (wr_act) begin
				wdata_r <= bus_i.data;
			end
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	wire [3:0] rd_word = (sel_r == `DTX_SEL_CTRL) ? status_r : rx_data_r;

	// Bus driven from the cycle after a read strobe starts until the cycle after it ends
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			data_out <= '0;
			data_oe_n <= 1'b1;
		end else begin
			data_out <= rd_word;
			data_oe_n <= ~rd_act;
		end
	end

	// ----------------------------------------
	// Transmit data and control registers
	// ----------------------------------------

	// Code kept in the same format the receiver reports
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tone_sel_r <= code_to_tone(`DTX_RX_RST);
			code_loaded_r <= 1'b0;
		end else if (wr_tx) begin
			tone_sel_r <= code_to_tone(wdata_r);
			code_loaded_r <= 1'b1;
		end
	end

	// Shared address; bank bit steers only the very next write
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_a_r <= `DTX_CTRL_RST;
			ctrl_b_r <= `DTX_CTRL_RST;
			bank_b_r <= 1'b0;
		end else if (wr_ctl) begin
			if (bank_b_r) begin
				ctrl_b_r <= wdata_r;
				bank_b_r <= 1'b0;
			end else begin
				ctrl_a_r <= wdata_r;
				bank_b_r <= wdata_r[3];
			end
		end
	end

	// ----------------------------------------
	// Burst and pause sequencer
	// ----------------------------------------
	wire burst_mode = ~ctrl_b_r.burst_off;
	// Odd lengths are left to the host toggling the tone bit
	wire [23:0] burst_len = ctrl_a_r.call_progress_select ? {BURST_CYC[22:0], 1'b0} : BURST_CYC;
	wire burst_done = (st_r == dtx_pkg::DTX_PAUSE) & (cnt_r == '0);

	// Next state; dropping the tone bit aborts without flagging ready
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - 24'h1;
		if (!ctrl_a_r.tone_output_on || !burst_mode) begin
			st_nxt = dtx_pkg::DTX_IDLE;
		end else begin
			unique case (st_r)
				dtx_pkg::DTX_IDLE: begin
					if (wr_tx) begin
						st_nxt = dtx_pkg::DTX_TONE;
						cnt_nxt = burst_len - 24'h1;
					end
				end
				dtx_pkg::DTX_TONE: begin
					if (cnt_r == '0) begin
						st_nxt = dtx_pkg::DTX_PAUSE;
						cnt_nxt = burst_len - 24'h1;
					end
				end
				dtx_pkg::DTX_PAUSE: begin
					if (cnt_r == '0) begin
						st_nxt = dtx_pkg::DTX_IDLE;
					end
				end
				default: st_nxt = dtx_pkg::DTX_IDLE;
			endcase
		end
	end

	// Sequencer state
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r <= dtx_pkg::DTX_IDLE;
			cnt_r <= '0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ----------------------------------------
	// Status flags and receive data
	// ----------------------------------------
	wire rx_take = rx_digit_valid & ~ctrl_a_r.call_progress_select;
	wire tx_ready_set = burst_done & ctrl_a_r.tone_output_on;
	wire irq_set = rx_take | tx_ready_set;

	// Set beats a clearing status read in the same cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			status_r <= '{steer_n: 1'b1, rx_ready: 1'b0, tx_empty: 1'b1, irq_pend: 1'b0};
			rx_data_r <= `DTX_RX_RST;
		end else begin
			status_r.steer_n <= rx_steer_n;
			status_r.rx_ready <= rx_take | (status_r.rx_ready & ~rd_stat_end);
			status_r.irq_pend <= irq_set | (status_r.irq_pend & ~rd_stat_end);
			status_r.tx_empty <= tx_ready_set | (status_r.tx_empty & ~(wr_tx & burst_mode));
			if (rx_take) begin
				rx_data_r <= rx_digit;
			end
		end
	end

	// ----------------------------------------
	// Alert pin and receiver enable
	// ----------------------------------------

	// Open drain: pull low for an alert, or mirror square wave / steering
	wire alert_low = ctrl_a_r.irq_en &
		(ctrl_a_r.call_progress_select ? ~rx_cp_square :
		(ctrl_b_r.test_mode ? ~rx_steer_n : status_r.irq_pend));

	// Pin level is fixed low; only the enable moves
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			host_alert_or_tone_out <= 1'b0;
			host_alert_or_tone_out_oe_n <= 1'b1;
			rx_enable <= 1'b1;
		end else begin
			host_alert_or_tone_out <= 1'b0;
			host_alert_or_tone_out_oe_n <= ~alert_low;
			rx_enable <= ~ctrl_a_r.call_progress_select;
		end
	end

	// ----------------------------------------
	// Tone synthesis, row path 0, column path 1
	// ----------------------------------------
	wire tone_on = ctrl_a_r.tone_output_on &
		(burst_mode ? (st_r == dtx_pkg::DTX_TONE) : code_loaded_r);
	wire row_on = ~ctrl_b_r.single_tone | ~ctrl_b_r.column_tone;
	wire col_on = ~ctrl_b_r.single_tone | ctrl_b_r.column_tone;
	wire [7:0] rom_q [2];

	generate
		for (genvar p = 0; p < 2; p++) begin : g_path
			logic [7:0] div_r;
			logic [4:0] phase_r;
			wire [3:0] oh = (p == 0) ? tone_sel_r.row : tone_sel_r.col;
			wire [7:0] len = seg_len(oh, p == 1);
			wire seg_end = xtal_tick_r & (div_r >= len - 8'h1);

			// Divider restarts at zero after the chosen count and steps the table address
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					div_r <= '0;
					phase_r <= '0;
				end else if (seg_end) begin
					div_r <= '0;
					phase_r <= phase_r + 5'h1;
				end else if (xtal_tick_r) begin
					div_r <= div_r + 8'h1;
				end
			end

			dtx_sine_rom #(
				.AW(5)
			) u_rom (
				.ref_clk(ref_clk),
				.addr(phase_r),
				.sample_r(rom_q[p])
			);
		end
	endgenerate

	// Silent paths sit at midscale
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			row_sample <= `DTX_MID;
			col_sample <= `DTX_MID;
			tone_active <= 1'b0;
		end else begin
			row_sample <= (tone_on & row_on) ? rom_q[0] : `DTX_MID;
			col_sample <= (tone_on & col_on) ? rom_q[1] : `DTX_MID;
			tone_active <= tone_on;
		end
	end

endmodule

/* File: tb/dtx_host_model.sv */
`timescale 1ns/1ps
module dtx_host_model (
	// Clock and device answer
	input wire logic ref_clk,
	input wire logic data_oe_n,
	// Bus pins toward the device
	output dtx_pkg::dtx_bus_in_t bus_o
);
	// Idle with select high and both strobes off
	initial bus_o = 8'he0;

	// One access; m picks the strobe style, w a write; every access opens with its own select fall
	task automatic acc(input logic m, input logic w, input logic s, input logic [3:0] d, output logic ok);
		ok = w;
		bus_o.data_strobe = ~m;
		@(negedge ref_clk);
		bus_o.cs_n = 1'b0;
		bus_o.reg_pick_line = s;
		bus_o.rw_wr = ~(m & w);
		@(negedge ref_clk);
		bus_o.data = w ? d : bus_o.data;
		if (m) begin
			bus_o.data_strobe = 1'b1;
		end else if (w) begin
			bus_o.rw_wr = 1'b0;
		end else begin
			bus_o.data_strobe = 1'b0;
		end
		@(negedge ref_clk);
		// Reads hold the strobe until the device drives the bus
		for (int n = 0; n < 8 && !ok; n++) begin
			ok = !data_oe_n;
			@(negedge ref_clk);
		end
		bus_o.data_strobe = ~m;
		bus_o.rw_wr = 1'b1;
		@(negedge ref_clk);
		bus_o.cs_n = 1'b1;
		// Released data must not look like the last value
		bus_o.data = ~bus_o.data;
	endtask
endmodule

/* File: tb/dtx_host_port_chk.sv */
`timescale 1ns/1ps
module dtx_host_port_chk #(
	parameter logic [23:0] BURST_CYC = 24'd50
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Host bus
	input wire dtx_pkg::dtx_bus_in_t bus_i,
	input wire logic data_oe_n,
	// Alert pin and receiver gate
	input wire logic host_alert_or_tone_out,
	input wire logic host_alert_or_tone_out_oe_n,
	input wire logic rx_enable,
	// Tone outputs
	input wire logic [7:0] row_sample,
	input wire logic [7:0] col_sample,
	input wire logic tone_active
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	logic cs_q, style_r, wr_q;
	int run_r, since_r;
	// Strobe style shadow and the live read and write terms
	wire cs_fall = cs_q && !bus_i.cs_n;
	wire sel_on = !bus_i.cs_n && !cs_fall;
	wire rd_on = sel_on && (style_r ? !bus_i.data_strobe : bus_i.data_strobe && bus_i.rw_wr);
	wire wr_on = sel_on && (style_r ? !bus_i.rw_wr : bus_i.data_strobe && !bus_i.rw_wr);
	// Tone run length and cycles since a write commit; saturating keeps the counter tiny
	always_ff @(posedge ref_clk) begin
		cs_q <= bus_i.cs_n;
		wr_q <= wr_on;
		style_r <= cs_fall ? bus_i.data_strobe : style_r;
		run_r <= tone_active ? run_r + 1 : 0;
		since_r <= srst ? 100 : (wr_q && !wr_on) ? 0 : (since_r < 100) ? since_r + 1 : since_r;
	end
	chk_alert_drive_low: assert property (host_alert_or_tone_out == 1'b0)
		else $error("alert pin level is not low");
	chk_read_drives_bus: assert property (rd_on |=> !data_oe_n)
		else $error("no bus drive after read strobe");
	chk_drive_needs_read: assert property (!data_oe_n |-> $past(rd_on))
		else $error("bus driven without a read");
	chk_drive_released: assert property ($fell(rd_on) |=> data_oe_n)
		else $error("bus still driven after read");
	chk_tone_needs_write: assert property ($rose(tone_active) |-> since_r < 4)
		else $error("tone started without a write");
	chk_burst_length: assert property ($fell(tone_active) |->
		run_r == int'(BURST_CYC) || run_r == 2 * int'(BURST_CYC) || since_r < 4)
		else $error("tone burst of wrong length");
	chk_rx_gate_write: assert property ($changed(rx_enable) |-> since_r < 4)
		else $error("receiver gate moved without a write");
	chk_silent_mid: assert property (!tone_active [*6] |-> row_sample == 8'h80 && col_sample == 8'h80)
		else $error("samples not at midscale while silent");
	chk_reset_idle: assert property ($fell(srst) |->
		data_oe_n && host_alert_or_tone_out_oe_n && rx_enable && !tone_active)
		else $error("outputs not idle after reset");
endmodule
bind dtx_host_port dtx_host_port_chk #(.BURST_CYC(BURST_CYC)) u_chk (.ref_clk, .srst, .bus_i, .data_oe_n,
	.host_alert_or_tone_out, .host_alert_or_tone_out_oe_n, .rx_enable, .row_sample, .col_sample, .tone_active);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
	localparam int NB = 50;
	logic ref_clk = 1'b0, srst = 1'b1, rx_digit_valid = 1'b0, rx_steer_n = 1'b1, rx_cp_square = 1'b0;
	logic data_oe_n, rx_enable, tone_active, host_alert_or_tone_out, host_alert_or_tone_out_oe_n, rm, cm;
	logic [3:0] rx_digit = 4'h0, data_out, d;
	logic [7:0] row_sample, col_sample;
	dtx_pkg::dtx_bus_in_t bus_i;
	logic [3:0] exp_q[$];
	int errors = 0, n_compared = 0, hi_cnt = 0, n, m;

	dtx_host_port #(.BURST_CYC(24'(NB))) u_dut (.ref_clk, .srst, .bus_i, .data_out, .data_oe_n,
		.host_alert_or_tone_out, .host_alert_or_tone_out_oe_n, .rx_digit_valid, .rx_digit, .rx_steer_n,
		.rx_cp_square, .rx_enable, .row_sample, .col_sample, .tone_active);
	dtx_host_model u_host (.ref_clk, .data_oe_n, .bus_o(bus_i));

	// Free-running 100 MHz clock
	initial forever #5 ref_clk = ~ref_clk;

	task automatic print_verdict();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("unexpected %s exp %0h got %0h", nm, e, g);
			errors++;
		end
	endtask

	// A bus access that never completes ends the run
	task automatic t(input logic mo, input logic w, input logic s, input logic [3:0] v);
		logic ok;
		u_host.acc(mo, w, s, v, ok);
		if (!ok) begin
			errors++;
			print_verdict();
		end
	endtask

	// Reads note their expected value first; the monitor scores them
	task automatic rd(input logic mo, input logic s, input logic [3:0] e);
		exp_q.push_back(e);
		t(mo, 1'b0, s, 4'h0);
	endtask

	task automatic wt(input logic v);
		int k;
		k = 0;
		while (tone_active !== v && k < 400) begin
			@(negedge ref_clk);
			k++;
		end
		if (k >= 400) begin
			errors++;
			print_verdict();
		end
	endtask

	// Cycles of tone, counted apart from the stimulus
	always @(negedge ref_clk) if (tone_active === 1'b1) hi_cnt++;

	// Read data is taken in the first cycle the device drives the bus
	initial begin
		logic oe_q;
		oe_q = 1'b1;
		forever begin
			@(negedge ref_clk);
			if (data_oe_n === 1'b0 && oe_q === 1'b1) begin
				if (exp_q.size() > 0) chk("data_out", 32'(exp_q.pop_front()), 32'(data_out));
				else chk("extra read", 0, 1);
			end
			oe_q = data_oe_n;
		end
	end

	initial begin
		n = $urandom(46359);
		repeat (5) @(negedge ref_clk);
		srst = 1'b0;
		chk("data_oe_n", 1, data_oe_n);
		chk("rx_enable", 1, rx_enable);
		chk("alert_oe_n", 1, host_alert_or_tone_out_oe_n);
		rd(1'b0, 1'b1, 4'ha);
		rd(1'b0, 1'b0, 4'h0);
		$display("test reset done");
		// Burst with both controls set up first, read and write strobe style
		t(1'b0, 1'b1, 1'b1, 4'hd);
		t(1'b0, 1'b1, 1'b1, 4'h0);
		hi_cnt = 0;
		t(1'b0, 1'b1, 1'b0, 4'($urandom()));
		rd(1'b0, 1'b1, 4'h8);
		wt(1'b0);
		n = 0;
		while (host_alert_or_tone_out_oe_n !== 1'b0 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		chk("burst", NB, hi_cnt);
		chk("pause", 1, n >= NB && n <= NB + 3);
		rd(1'b0, 1'b1, 4'hb);
		rd(1'b0, 1'b1, 4'ha);
		chk("alert_oe_n", 1, host_alert_or_tone_out_oe_n);
		$display("test burst done");
		// Call progress doubles the burst and keeps the receiver off
		t(1'b0, 1'b1, 1'b1, 4'h3);
		repeat (4) @(negedge ref_clk);
		chk("rx_enable", 0, rx_enable);
		hi_cnt = 0;
		t(1'b0, 1'b1, 1'b0, 4'($urandom()));
		wt(1'b1);
		rx_digit = 4'($urandom());
		rx_digit_valid = 1'b1;
		@(negedge ref_clk);
		rx_digit_valid = 1'b0;
		wt(1'b0);
		chk("cp burst", 2 * NB, hi_cnt);
		repeat (2 * NB + 4) @(negedge ref_clk);
		rd(1'b1, 1'b1, 4'hb);
		rd(1'b1, 1'b0, 4'h0);
		$display("test call progress done");
		// Row only, column only, then both, with burst off and strobe style
		for (m = 0; m < 3; m++) begin
			t(1'b1, 1'b1, 1'b1, 4'h9);
			t(1'b1, 1'b1, 1'b1, (m == 2) ? 4'h1 : {m[0], 3'b101});
			repeat (4) @(negedge ref_clk);
			rm = 1'b0;
			cm = 1'b0;
			repeat (6000) begin
				@(negedge ref_clk);
				rm |= row_sample !== 8'h80;
				cm |= col_sample !== 8'h80;
			end
			chk("row moving", m != 1, rm);
			chk("col moving", m != 0, cm);
		end
		t(1'b1, 1'b1, 1'b1, 4'h4);
		repeat (4) @(negedge ref_clk);
		chk("tone_active", 0, tone_active);
		$display("test tone select done");
		// A received digit raises the alert until status is read
		d = 4'($urandom());
		rx_digit = d;
		rx_steer_n = 1'b0;
		rx_digit_valid = 1'b1;
		@(negedge ref_clk);
		rx_digit_valid = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("alert_oe_n", 0, host_alert_or_tone_out_oe_n);
		rd(1'b1, 1'b0, d);
		rd(1'b1, 1'b1, 4'h7);
		rd(1'b0, 1'b1, 4'h2);
		chk("alert_oe_n", 1, host_alert_or_tone_out_oe_n);
		chk("reads left", 0, exp_q.size());
		$display("test receive done");
		// Test mode mirrors delayed steering on the pin, call progress the square wave
		t(1'b0, 1'b1, 1'b1, 4'hc);
		t(1'b0, 1'b1, 1'b1, 4'h2);
		rx_steer_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk("alert_oe_n", 1, host_alert_or_tone_out_oe_n);
		rx_steer_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("alert_oe_n", 0, host_alert_or_tone_out_oe_n);
		t(1'b0, 1'b1, 1'b1, 4'h6);
		for (m = 0; m < 2; m++) begin
			rx_cp_square = m[0];
			repeat (3) @(negedge ref_clk);
			chk("alert_oe_n", m[0], host_alert_or_tone_out_oe_n);
		end
		$display("test alert done");
		print_verdict();
	end
endmodule
